// ---- design/obcrc_pkg.sv ----
// shared constants and types for the option byte clock and reset decoder
`default_nettype none
package obcrc_pkg;

	// register byte addresses
	localparam logic [3:0] OBCRC_ADDR_OPTION = 4'h0;
	localparam logic [3:0] OBCRC_ADDR_DECODE = 4'h4;
	localparam logic [3:0] OBCRC_ADDR_STATUS = 4'h8;
	localparam logic [3:0] OBCRC_ADDR_CTRL = 4'hC;

	// axi response codes
	localparam logic [1:0] OBCRC_RESP_OKAY = 2'h0;
	localparam logic [1:0] OBCRC_RESP_SLVERR = 2'h2;

	// status and control bit positions
	localparam int OBCRC_ST_RESET_PHASE = 0;
	localparam int OBCRC_ST_HALTED = 1;
	localparam int OBCRC_ST_STABILIZING = 2;
	localparam int OBCRC_ST_PKG_INVALID = 3;
	localparam int OBCRC_ST_SRC_RESERVED = 4;
	localparam int OBCRC_ST_DOUBLER_MISUSE = 5;
	localparam int OBCRC_ST_SAMPLED = 6;
	localparam int OBCRC_CTRL_HALT = 0;

	// reset phase lengths in cpu cycles and delay counter width
	localparam int OBCRC_LONG_CYCLES = 4096;
	localparam int OBCRC_SHORT_CYCLES = 256;
	localparam int OBCRC_CNT_W = 13;

	// default option byte content and pad layout
	localparam logic [7:0] OBCRC_OPTION_DEFAULT = 8'hEF;
	localparam int OBCRC_PORT_COUNT = 6;
	localparam int OBCRC_PADS_PER_PORT = 8;
	localparam logic [47:0] OBCRC_UNBONDED_44 = 48'hFFFF_0000_0000;
	localparam logic [47:0] OBCRC_PADS_ALL = 48'hFFFF_FFFF_FFFF;

	// field encodings
	localparam logic [1:0] OBCRC_SRC_RESONATOR = 2'h0;
	localparam logic [1:0] OBCRC_SRC_RESERVED = 2'h1;
	localparam logic [1:0] OBCRC_SRC_INTERNAL_RC = 2'h2;
	localparam logic [1:0] OBCRC_SRC_EXTERNAL = 2'h3;
	localparam logic [2:0] OBCRC_RANGE_1_TO_2MHZ = 3'h0;
	localparam logic [2:0] OBCRC_RANGE_2_TO_4MHZ = 3'h1;
	localparam logic [2:0] OBCRC_RANGE_4_TO_8MHZ = 3'h2;
	localparam logic [2:0] OBCRC_RANGE_8_TO_16MHZ = 3'h3;

	// option byte layout, msb first
	typedef struct packed {
		logic package_select_high;
		logic reset_length_select;
		logic [1:0] clock_source_type;
		logic [2:0] oscillator_range;
		logic doubler_disable;
	} obcrc_option_t;

	// option bit that lives in the neighbouring byte
	localparam int OBCRC_PKG_LOW_POS = 1;

	// decoded configuration held until the next reset
	typedef struct packed {
		logic package_64;
		logic package_invalid;
		logic src_resonator;
		logic src_internal_rc;
		logic src_external;
		logic src_reserved;
		logic [2:0] osc_current_sel;
		logic [2:0] freq_range_sel;
		logic doubler_enable;
		logic short_reset;
		logic readout_protect;
	} obcrc_decode_t;

	localparam int OBCRC_DECODE_W = 15;

endpackage
`default_nettype wire

// ---- design/obcrc_delay_counter.sv ----
// down counter that holds busy for a loaded number of cycles
`timescale 1ns/1ps
`default_nettype none
module obcrc_delay_counter #(
	parameter int W = 13
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [W-1:0] cycles,
	output logic busy
);
	logic [W-1:0] cnt_q;
	logic busy_q;

	assign busy = busy_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
		end else if (start) begin
			busy_q <= 1'b1;
			cnt_q <= cycles - W'(1);
		end else if (busy_q) begin
			if (cnt_q == '0) begin
				busy_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/obcrc_top.sv ----
// option byte decoder: package, reset length, clock source, doubler
// Notes on behaviour
// - two option bits select 64 or 44 leads
// - unbonded pads come up input with pull-up
// - reset phase 4096 cycles or 256 cycles
// - same delay applied when leaving halt
// - two bits pick main clock source type
// - resonator: range field sets oscillator current
// - other sources: range field means frequency range
// - disable bit zero enables clock doubler
// - read protection polarity inverted in mask variant
// - option bits written only in programming mode
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module obcrc_top
	import obcrc_pkg::*;
#(
	parameter bit MASK_VARIANT = 1'b0,
	parameter logic [7:0] MASK_OPTION = OBCRC_OPTION_DEFAULT,
	parameter logic MASK_PKG_LOW = 1'b0,
	parameter logic MASK_READOUT = 1'b0,
	parameter int LONG_CYCLES = OBCRC_LONG_CYCLES,
	parameter int SHORT_CYCLES = OBCRC_SHORT_CYCLES,
	parameter int PADS = OBCRC_PORT_COUNT * OBCRC_PADS_PER_PORT,
	parameter logic [PADS-1:0] UNBONDED_44 = OBCRC_UNBONDED_44
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire obcrc_pkg::obcrc_option_t option_nv,
	input wire logic pkg_low_nv,
	input wire logic readout_nv,
	input wire logic prog_mode,
	input wire logic prog_wr,
	input wire logic [7:0] prog_data,
	input wire logic wake_event,
	output logic nv_wr_q,
	output logic [7:0] nv_wr_data_q,
	output obcrc_pkg::obcrc_decode_t decode_q,
	output logic cpu_reset_hold_q,
	output logic clock_stopped_q,
	output logic [PADS-1:0] pad_force_input_q,
	output logic [PADS-1:0] pad_force_pullup_q
);
	import obcrc_pkg::*;

	obcrc_option_t opt_q;
	logic pkg_low_q;
	logic readout_raw_q;
	logic sampled_q;
	logic capture;
	logic start_delay;
	logic delay_busy;
	logic [OBCRC_CNT_W-1:0] delay_cycles;
	logic halt_q;
	logic stab_q;
	logic aw_full_q;
	logic w_full_q;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic halt_req;
	logic [31:0] status_word;
	logic [31:0] decode_word;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// caught on the first edge after release so reset never loads a port
	assign capture = !sampled_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sampled_q <= 1'b0;
			opt_q <= OBCRC_OPTION_DEFAULT;
			pkg_low_q <= 1'b0;
			readout_raw_q <= 1'b1;
		end else if (capture) begin
			sampled_q <= 1'b1;
			// mask parts carry the byte in metal, flash parts in cells
			opt_q <= MASK_VARIANT ? obcrc_option_t'(MASK_OPTION)
				: option_nv;
			pkg_low_q <= MASK_VARIANT ? MASK_PKG_LOW : pkg_low_nv;
			readout_raw_q <= MASK_VARIANT ? MASK_READOUT : readout_nv;
		end
	end

	// the programming tool path; dead in mask parts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nv_wr_q <= 1'b0;
			nv_wr_data_q <= 8'h00;
		end else begin
			nv_wr_q <= prog_mode && prog_wr && !MASK_VARIANT;
			if (prog_mode && prog_wr) begin
				nv_wr_data_q <= prog_data;
			end
		end
	end

	// decoded fields settle one edge after capture, then stay put
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			decode_q <= '0;
		end else if (sampled_q) begin
			decode_q.package_64 <= opt_q.package_select_high
				&& !pkg_low_q;
			decode_q.package_invalid <= pkg_low_q;
			decode_q.src_resonator <= opt_q.clock_source_type
				== OBCRC_SRC_RESONATOR;
			decode_q.src_reserved <= opt_q.clock_source_type
				== OBCRC_SRC_RESERVED;
			decode_q.src_internal_rc <= opt_q.clock_source_type
				== OBCRC_SRC_INTERNAL_RC;
			decode_q.src_external <= opt_q.clock_source_type
				== OBCRC_SRC_EXTERNAL;
			if (opt_q.clock_source_type == OBCRC_SRC_RESONATOR) begin
				decode_q.osc_current_sel <= opt_q.oscillator_range;
				decode_q.freq_range_sel <= 3'h0;
			end else begin
				decode_q.osc_current_sel <= 3'h0;
				decode_q.freq_range_sel <= opt_q.oscillator_range;
			end
			decode_q.doubler_enable <= !opt_q.doubler_disable;
			decode_q.short_reset <= opt_q.reset_length_select;
			// flash: 0 protects; mask: 1 protects
			decode_q.readout_protect <= MASK_VARIANT ? readout_raw_q
				: !readout_raw_q;
		end
	end

	// pads that the small package leaves open stay input with pull-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_force_input_q <= OBCRC_PADS_ALL[PADS-1:0];
			pad_force_pullup_q <= OBCRC_PADS_ALL[PADS-1:0];
		end else if (sampled_q) begin
			if (opt_q.package_select_high && !pkg_low_q) begin
				pad_force_input_q <= '0;
				pad_force_pullup_q <= '0;
			end else begin
				pad_force_input_q <= UNBONDED_44;
				pad_force_pullup_q <= UNBONDED_44;
			end
		end
	end

	// one counter serves reset phase and halt exit alike
	assign delay_cycles = opt_q.reset_length_select
		? OBCRC_CNT_W'(SHORT_CYCLES) : OBCRC_CNT_W'(LONG_CYCLES);
	logic capture_start_q;
	assign start_delay = capture_start_q
		|| (halt_q && wake_event && !stab_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_start_q <= 1'b0;
		end else begin
			capture_start_q <= capture;
		end
	end

	obcrc_delay_counter #(
		.W(OBCRC_CNT_W)
	) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start_delay),
		.cycles(delay_cycles),
		.busy(delay_busy)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_reset_hold_q <= 1'b1;
		end else if (sampled_q && !capture_start_q && !delay_busy
			&& !stab_q) begin
			cpu_reset_hold_q <= 1'b0;
		end
	end

	// halt: entered by software, left by wake after the stabilisation wait
	assign halt_req = do_write && (aw_addr_q == OBCRC_ADDR_CTRL)
		&& w_strb_q[0] && w_data_q[OBCRC_CTRL_HALT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_q <= 1'b0;
			stab_q <= 1'b0;
		end else begin
			if (halt_q && wake_event && !stab_q) begin
				stab_q <= 1'b1;
			end else if (stab_q && !delay_busy) begin
				stab_q <= 1'b0;
				halt_q <= 1'b0;
			end else if (halt_req && !cpu_reset_hold_q) begin
				halt_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_stopped_q <= 1'b0;
		end else begin
			clock_stopped_q <= halt_req && !cpu_reset_hold_q
				|| (halt_q && !(stab_q && !delay_busy));
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[OBCRC_ST_RESET_PHASE] = cpu_reset_hold_q;
		status_word[OBCRC_ST_HALTED] = halt_q;
		status_word[OBCRC_ST_STABILIZING] = stab_q;
		status_word[OBCRC_ST_PKG_INVALID] = decode_q.package_invalid;
		status_word[OBCRC_ST_SRC_RESERVED] = decode_q.src_reserved;
		// flags a configuration the tool should never have written
		status_word[OBCRC_ST_DOUBLER_MISUSE] = decode_q.doubler_enable
			&& (decode_q.src_internal_rc
			|| (opt_q.oscillator_range != OBCRC_RANGE_2_TO_4MHZ));
		status_word[OBCRC_ST_SAMPLED] = sampled_q;
	end

	assign decode_word = {{(32-OBCRC_DECODE_W){1'b0}}, decode_q};

	// write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			aw_full_q <= 1'b0;
			aw_addr_q <= 4'h0;
		end else begin
			if (awready_q && s_axi_awvalid) begin
				awready_q <= 1'b0;
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_q <= 1'b0;
			end else if (!aw_full_q && !bvalid_q) begin
				awready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_q <= 1'b0;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (wready_q && s_axi_wvalid) begin
				wready_q <= 1'b0;
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_full_q <= 1'b0;
			end else if (!w_full_q && !bvalid_q) begin
				wready_q <= 1'b1;
			end
		end
	end

	assign do_write = aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= OBCRC_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			case (aw_addr_q)
				OBCRC_ADDR_OPTION, OBCRC_ADDR_DECODE, OBCRC_ADDR_STATUS,
				OBCRC_ADDR_CTRL: begin
					bresp_q <= OBCRC_RESP_OKAY;
				end
				default: begin
					bresp_q <= OBCRC_RESP_SLVERR;
				end
			endcase
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= OBCRC_RESP_OKAY;
		end else if (arready_q && s_axi_arvalid) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= OBCRC_RESP_OKAY;
			case (s_axi_araddr)
				OBCRC_ADDR_OPTION: begin
					rdata_q <= {24'h00_0000, opt_q};
				end
				OBCRC_ADDR_DECODE: begin
					rdata_q <= decode_word;
				end
				OBCRC_ADDR_STATUS: begin
					rdata_q <= status_word;
				end
				OBCRC_ADDR_CTRL: begin
					rdata_q <= {31'h0000_0000, halt_q};
				end
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= OBCRC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- verif/obcrc_monitor.sv ----
// port checks for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module obcrc_monitor
	import obcrc_pkg::*;
#(
	parameter int PADS = 48,
	parameter logic [PADS-1:0] UNBONDED_44 = OBCRC_UNBONDED_44,
	parameter int LONG_CYCLES = OBCRC_LONG_CYCLES,
	parameter int SHORT_CYCLES = OBCRC_SHORT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic prog_mode,
	input wire logic prog_wr,
	input wire logic [7:0] prog_data,
	input wire logic wake_event,
	input wire logic nv_wr_q,
	input wire logic [7:0] nv_wr_data_q,
	input wire obcrc_pkg::obcrc_decode_t decode_q,
	input wire logic cpu_reset_hold_q,
	input wire logic clock_stopped_q,
	input wire logic [PADS-1:0] pad_force_input_q,
	input wire logic [PADS-1:0] pad_force_pullup_q
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [12:0] hold_cnt_q;
	int n_cyc;
	assign n_cyc = decode_q.short_reset ? SHORT_CYCLES : LONG_CYCLES;
	// too long for a repetition, so the reset phase is counted here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_cnt_q <= 13'h0;
		end else if (cpu_reset_hold_q) begin
			hold_cnt_q <= hold_cnt_q + 13'h1;
		end
	end
	// halt exit is only timed with the short count
	sequence wake_s;
		clock_stopped_q && $rose(wake_event) && decode_q.short_reset;
	endsequence
	sequence stopped_s;
		clock_stopped_q [*3];
	endsequence
	a_nv_write_gate: assert property (
		nv_wr_q |-> $past(prog_mode && prog_wr)) else $error("stray nv write");
	a_nv_write_take: assert property (
		prog_mode && prog_wr |=> nv_wr_q && nv_wr_data_q == $past(prog_data))
		else $error("nv write lost");
	a_config_hold: assert property (
		!cpu_reset_hold_q && !$past(cpu_reset_hold_q) |->
		$stable(decode_q) && $stable(pad_force_input_q))
		else $error("config changed");
	a_pad_pullup: assert property (
		pad_force_input_q == pad_force_pullup_q) else $error("pull-up split");
	a_pad_bonded: assert property (
		!cpu_reset_hold_q |-> pad_force_input_q ==
		(decode_q.package_64 ? '0 : UNBONDED_44)) else $error("pad set");
	a_src_onehot: assert property (
		!cpu_reset_hold_q |-> $onehot({decode_q.src_resonator,
		decode_q.src_internal_rc, decode_q.src_external,
		decode_q.src_reserved})) else $error("source decode");
	a_range_split: assert property (
		!cpu_reset_hold_q |-> (decode_q.src_resonator ?
		decode_q.freq_range_sel : decode_q.osc_current_sel) == 3'h0)
		else $error("range split");
	a_reset_length: assert property (
		$fell(cpu_reset_hold_q) |-> hold_cnt_q >= n_cyc &&
		hold_cnt_q <= n_cyc + 4) else $error("reset length");
	a_halt_length: assert property (
		wake_s |-> stopped_s ##[1:6] !clock_stopped_q)
		else $error("halt exit");
endmodule
`default_nettype wire

// ---- verif/obcrc_prog_tool.sv ----
// programming tool model holding the option byte cells
`timescale 1ns/1ps
`default_nettype none
module obcrc_prog_tool
	import obcrc_pkg::*;
(
	input wire logic aclk,
	input wire logic nv_wr,
	input wire logic [7:0] nv_wr_data,
	output var obcrc_pkg::obcrc_option_t cell_q
);
	obcrc_option_t d;
	initial cell_q = OBCRC_OPTION_DEFAULT;
	always @(posedge aclk) begin
		if (nv_wr) begin
			d = nv_wr_data;
			// doubler left off where it cannot lock
			if (d.oscillator_range != OBCRC_RANGE_2_TO_4MHZ ||
				d.clock_source_type == OBCRC_SRC_INTERNAL_RC) begin
				d.doubler_disable = 1'b1;
			end
			// crystals need the long settling time
			if (d.clock_source_type == OBCRC_SRC_RESONATOR) begin
				d.reset_length_select = 1'b0;
			end
			cell_q <= d;
		end
	end
endmodule
`default_nettype wire

// ---- verif/obcrc_top_tb.sv ----
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module obcrc_top_tb;
	import obcrc_pkg::*;
	localparam int LONG = 16;
	localparam int SHORT = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	obcrc_option_t option_nv;
	logic pkg_low_nv = 1'b0, readout_nv = 1'b1, wake_event = 1'b0;
	logic prog_mode = 1'b0, prog_wr = 1'b0;
	logic [7:0] prog_data = 8'h00, nv_wr_data_q;
	logic nv_wr_q, cpu_reset_hold_q, clock_stopped_q;
	obcrc_decode_t decode_q;
	logic [47:0] pad_force_input_q, pad_force_pullup_q;
	int n_fail = 0;
	int total_checks = 0;
	int cyc;
	int n;
	logic [24:0] row;
	// option byte, low select, raw protect bit, expected decode
	logic [24:0] rows [6] = '{
		{8'h82, 2'b00, 15'h5045},
		{8'h67, 2'b01, 15'h081A},
		{8'h75, 2'b11, 15'h2412},
		{8'h91, 2'b01, 15'h4200},
		{8'h87, 2'b01, 15'h50C0},
		{8'h05, 2'b01, 15'h1080}
	};
	always #50 aclk = ~aclk;
	obcrc_top #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) u_obcrc_top (.*);
	obcrc_prog_tool u_obcrc_prog_tool (.aclk(aclk), .nv_wr(nv_wr_q),
		.nv_wr_data(nv_wr_data_q), .cell_q(option_nv));
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic prog(input logic [7:0] b);
		@(posedge aclk);
		prog_mode <= 1'b1;
		prog_wr <= 1'b1;
		prog_data <= b;
		@(posedge aclk);
		prog_wr <= 1'b0;
		repeat (3) @(posedge aclk);
		prog_mode <= 1'b0;
	endtask
	// counts edges until the cpu leaves its reset phase
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		chk(cpu_reset_hold_q === 1'b1 && &pad_force_input_q === 1'b1, "rst");
		aresetn <= 1'b1;
		cyc = 0;
		do begin
			@(posedge aclk);
			cyc++;
		end while (cpu_reset_hold_q !== 1'b0 && cyc < 9999);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		$display("FAIL %0t watchdog", $time);
		finish_test();
	end
	initial begin
		do_reset();
		for (int i = 0; i < 6; i++) begin
			row = rows[i];
			prog(row[24:17]);
			pkg_low_nv <= row[16];
			readout_nv <= row[15];
			do_reset();
			n = row[23] ? SHORT : LONG;
			chk(cyc >= n && cyc <= n + 4, "reset length");
			chk(decode_q === row[14:0], "decode");
			chk(pad_force_input_q === (row[14] ? 48'h0 : OBCRC_UNBONDED_44), "pads");
			axi_rd(OBCRC_ADDR_OPTION);
			chk(rd === {24'h0, row[24:17]} && rs === OBCRC_RESP_OKAY, "opt");
			$display("row %0d done", i);
		end
		prog(8'hFF);
		chk(decode_q === 15'h1080, "held decode");
		chk(option_nv === 8'hFF, "cell write");
		// a write strobe outside programming mode must not reach the cells
		@(posedge aclk);
		prog_data <= 8'h00;
		prog_wr <= 1'b1;
		@(posedge aclk);
		prog_wr <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(option_nv === 8'hFF, "locked cell");
		do_reset();
		chk(decode_q === 15'h443A, "external source");
		axi_wr(OBCRC_ADDR_CTRL, 32'h1);
		repeat (2) @(posedge aclk);
		chk(clock_stopped_q === 1'b1, "halted");
		wake_event <= 1'b1;
		@(posedge aclk);
		wake_event <= 1'b0;
		cyc = 0;
		do begin
			@(posedge aclk);
			cyc++;
		end while (clock_stopped_q !== 1'b0 && cyc < 9999);
		chk(cyc >= SHORT && cyc <= SHORT + 4, "halt exit");
		axi_rd(4'h2);
		chk(rs === OBCRC_RESP_SLVERR && rd === 32'h0, "unmapped");
		axi_wr(OBCRC_ADDR_OPTION, 32'h0);
		axi_rd(OBCRC_ADDR_OPTION);
		chk(rd === 32'hFF, "read-only option");
		$display("halt and bus tests done");
		finish_test();
	end
endmodule
bind obcrc_top obcrc_monitor #(.PADS(PADS), .UNBONDED_44(UNBONDED_44),
	.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_obcrc_monitor (.*);
`default_nettype wire
